/* File: led_status_pkg.sv */
// Constants and encodings for the safe I/O status indicator block
// Contract
// - With the module supply absent the module-state indicator is dark; the code instead shows a pending critical error in red.
// - A pending repairable external error flashes the module-state indicator red and green at 1 Hz.
// - Stop state or supply outside 16.8 V to 30 V flashes the module-state indicator green at 1 Hz.
// - Run state with supply inside 16.8 V to 30 V lights the module-state indicator steady green.
// - A critical error here flashes the module-state indicator red at 2 Hz and stops the application.
// - A critical error elsewhere lights the module-state indicator steady red and stops the application.
// - Any critical error forces every safe output off.
// - An input indicator is dark while its input is at 0 V with no error pending.
// - Safety-mat channels with both inputs actuated keep their input indicators dark.
// - An input indicator glows green while its input is at 24 V with no error pending.
// - Input at 0 V with a dual-channel error pending blinks green 1 Hz in phase with the red blink.
// - Input at 24 V with an error pending blinks green 1 Hz in antiphase with the red blink.
// - An output with a test error blinks green 1 Hz in phase with the red blink.
// - An output indicator is dark while its output is off with no test error.
package led_status_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BLINK_FAST_HZ = 2;
  // Half period of the 2 Hz blink; 1 Hz phase toggles every second one
  localparam int unsigned HALF_FAST_CYCLES = CLK_HZ / (2 * BLINK_FAST_HZ);
  localparam int unsigned INPUT_CHANNELS = 8;
  localparam int unsigned OUTPUT_CHANNELS = 4;

  typedef enum logic [6:0] {
    MOD_DARK = 7'h01,
    MOD_CRIT_HERE = 7'h02,
    MOD_CRIT_OTHER = 7'h04,
    MOD_EXT_ERROR = 7'h08,
    MOD_STOP = 7'h10,
    MOD_RUN = 7'h20,
    MOD_SUPPLY_LOW = 7'h40
  } mod_state_t;
endpackage : led_status_pkg

/* File: blink_divider.sv */
// Shared blink-phase divider producing aligned 1 Hz and 2 Hz phases
`timescale 1ns/1ps
`default_nettype none
module blink_divider #(
  parameter int unsigned HALF_CYCLES = led_status_pkg::HALF_FAST_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Phases
  output logic phase_fast_out,
  output logic phase_slow_out
);
  localparam int unsigned CW = $clog2(HALF_CYCLES + 1);
  logic [CW-1:0] count;
  logic tick;

  assign tick = (count == CW'(HALF_CYCLES - 1));

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (tick) begin
      count <= '0;
    end else begin
      count <= count + CW'(1);
    end
  end

  // Slow phase flips on every second fast edge, so the two never drift
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_fast_out <= 1'b0;
      phase_slow_out <= 1'b0;
    end else if (tick) begin
      phase_fast_out <= ~phase_fast_out;
      if (phase_fast_out) begin
        phase_slow_out <= ~phase_slow_out;
      end
    end
  end

  half_period_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    tick |=> (count == '0)) else $error("divider did not wrap");
  slow_follows_fast_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $changed(phase_slow_out) |-> $fell(phase_fast_out))
    else $error("slow phase out of step");
endmodule : blink_divider
`default_nettype wire

/* File: channel_indicator.sv */
// Per-channel indicator pattern selection for inputs and outputs
`timescale 1ns/1ps
`default_nettype none
module channel_indicator #(
  parameter int unsigned CHANNELS = led_status_pkg::INPUT_CHANNELS,
  parameter bit IS_OUTPUT = 1'b0
) (
  // Channel state
  input wire logic [CHANNELS-1:0] level_in,
  input wire logic [CHANNELS-1:0] error_in,
  input wire logic [CHANNELS-1:0] dual_error_in,
  input wire logic [CHANNELS-1:0] mat_actuated_in,
  // Shared 1 Hz phase, high when the red module-state blink is lit
  input wire logic phase_slow_in,
  // Next indicator value
  output logic [CHANNELS-1:0] next_led_out
);
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      if (IS_OUTPUT) begin : g_out
        // Test error blinks with the red phase, else follows output
        assign next_led_out[ch] = error_in[ch] ? phase_slow_in : level_in[ch];
      end else begin : g_in
        // Mat actuation overrides level; errors blink in or out of phase
        assign next_led_out[ch] =
            mat_actuated_in[ch] ? 1'b0 :
            (level_in[ch] && error_in[ch]) ? ~phase_slow_in :
            (!level_in[ch] && dual_error_in[ch]) ? phase_slow_in :
            level_in[ch];
      end
    end
  endgenerate
endmodule : channel_indicator
`default_nettype wire

/* File: safe_io_led_status_indicator.sv */
// Status indicator logic for a safe input/output expansion module
`timescale 1ns/1ps
`default_nettype none
module safe_io_led_status_indicator #(
  parameter int unsigned HALF_CYCLES = led_status_pkg::HALF_FAST_CYCLES,
  parameter int unsigned IN_CH = led_status_pkg::INPUT_CHANNELS,
  parameter int unsigned OUT_CH = led_status_pkg::OUTPUT_CHANNELS
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Module conditions
  input wire logic supply_absent_in,
  input wire logic supply_window_fail_in,
  input wire logic run_in,
  input wire logic critical_here_in,
  input wire logic critical_other_in,
  // Input channels
  input wire logic [IN_CH-1:0] safe_input_channels_in,
  input wire logic [IN_CH-1:0] input_error_in,
  input wire logic [IN_CH-1:0] input_dual_error_in,
  input wire logic [IN_CH-1:0] safety_mat_actuated_in,
  // Output channels
  input wire logic [OUT_CH-1:0] output_request_in,
  input wire logic [OUT_CH-1:0] output_test_error_in,
  // Module-state indicator
  output logic mod_red_out,
  output logic mod_green_out,
  // Channel indicators
  output logic [IN_CH-1:0] input_led_out,
  output logic [OUT_CH-1:0] output_led_out,
  // Safe outputs and application stop
  output logic [OUT_CH-1:0] safe_output_channels_out,
  output logic app_stop_out
);
  logic phase_fast;
  logic phase_slow;
  logic critical;
  logic ext_error;
  led_status_pkg::mod_state_t mod_state;
  led_status_pkg::mod_state_t next_mod_state;
  logic next_red;
  logic next_green;
  logic [IN_CH-1:0] next_input_led;
  logic [OUT_CH-1:0] next_output_led;

  blink_divider #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_divider (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .phase_fast_out(phase_fast),
    .phase_slow_out(phase_slow)
  );

  assign critical = critical_here_in | critical_other_in;
  assign ext_error = (|input_error_in) | (|input_dual_error_in) | (|output_test_error_in);

  // Priority of module-state conditions
  always_comb begin
    if (critical_here_in) begin
      next_mod_state = led_status_pkg::MOD_CRIT_HERE;
    end else if (critical_other_in) begin
      next_mod_state = led_status_pkg::MOD_CRIT_OTHER;
    end else if (supply_absent_in) begin
      next_mod_state = led_status_pkg::MOD_DARK;
    end else if (supply_window_fail_in) begin
      next_mod_state = led_status_pkg::MOD_SUPPLY_LOW;
    end else if (ext_error) begin
      next_mod_state = led_status_pkg::MOD_EXT_ERROR;
    end else if (!run_in) begin
      next_mod_state = led_status_pkg::MOD_STOP;
    end else begin
      next_mod_state = led_status_pkg::MOD_RUN;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      mod_state <= led_status_pkg::MOD_DARK;
    end else begin
      mod_state <= next_mod_state;
    end
  end

  // Pattern decode; colours registered so the pins are glitch free
  always_comb begin
    case (mod_state)
      led_status_pkg::MOD_CRIT_HERE: begin
        next_red = phase_fast;
        next_green = 1'b0;
      end
      led_status_pkg::MOD_CRIT_OTHER: begin
        next_red = 1'b1;
        next_green = 1'b0;
      end
      led_status_pkg::MOD_EXT_ERROR: begin
        next_red = phase_slow;
        next_green = ~phase_slow;
      end
      led_status_pkg::MOD_STOP, led_status_pkg::MOD_SUPPLY_LOW: begin
        next_red = 1'b0;
        next_green = phase_slow;
      end
      led_status_pkg::MOD_RUN: begin
        next_red = 1'b0;
        next_green = 1'b1;
      end
      default: begin
        next_red = 1'b0;
        next_green = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      mod_red_out <= 1'b0;
      mod_green_out <= 1'b0;
    end else begin
      mod_red_out <= next_red;
      mod_green_out <= next_green;
    end
  end

  channel_indicator #(
    .CHANNELS(IN_CH),
    .IS_OUTPUT(1'b0)
  ) u_inputs (
    .level_in(safe_input_channels_in),
    .error_in(input_error_in),
    .dual_error_in(input_dual_error_in),
    .mat_actuated_in(safety_mat_actuated_in),
    .phase_slow_in(phase_slow),
    .next_led_out(next_input_led)
  );

  // Output indicator follows the actual, forced output state
  channel_indicator #(
    .CHANNELS(OUT_CH),
    .IS_OUTPUT(1'b1)
  ) u_outputs (
    .level_in(output_request_in & {OUT_CH{~critical}}),
    .error_in(output_test_error_in),
    .dual_error_in({OUT_CH{1'b0}}),
    .mat_actuated_in({OUT_CH{1'b0}}),
    .phase_slow_in(phase_slow),
    .next_led_out(next_output_led)
  );

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      input_led_out <= '0;
      output_led_out <= '0;
    end else begin
      input_led_out <= next_input_led;
      output_led_out <= next_output_led;
    end
  end

  // Critical error wins over any output request; outputs start off
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      safe_output_channels_out <= '0;
      app_stop_out <= 1'b1;
    end else begin
      safe_output_channels_out <= critical ? '0 : output_request_in;
      app_stop_out <= critical | ~run_in;
    end
  end

  sequence crit_seen_s;
    critical_here_in || critical_other_in;
  endsequence

  // No critical error and the supply fully in range
  sequence supply_good_s;
    !critical && !supply_absent_in && !supply_window_fail_in;
  endsequence

  outputs_forced_off_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    crit_seen_s |=> (safe_output_channels_out == '0) && app_stop_out)
    else $error("outputs not forced off on critical error");

  outputs_follow_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !critical |=> safe_output_channels_out == $past(output_request_in))
    else $error("safe outputs do not follow request");

  stop_here_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    critical_here_in |=> app_stop_out) else $error("application not stopped");

  stop_other_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    critical_other_in |=> app_stop_out) else $error("application not stopped");

  // State register tracks the condition priority one cycle later
  state_onehot_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $onehot(mod_state)) else $error("state not one-hot");

  prio_here_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    critical_here_in |=> mod_state == led_status_pkg::MOD_CRIT_HERE)
    else $error("critical here not chosen");

  prio_other_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical_here_in && critical_other_in) |=> mod_state == led_status_pkg::MOD_CRIT_OTHER)
    else $error("critical elsewhere not chosen");

  prio_dark_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical && supply_absent_in) |=> mod_state == led_status_pkg::MOD_DARK)
    else $error("supply failure not chosen");

  prio_window_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical && !supply_absent_in && supply_window_fail_in)
    |=> mod_state == led_status_pkg::MOD_SUPPLY_LOW)
    else $error("window failure not chosen");

  prio_error_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    supply_good_s ##0 ext_error |=> mod_state == led_status_pkg::MOD_EXT_ERROR)
    else $error("repairable error not chosen");

  prio_stop_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    supply_good_s ##0 (!ext_error && !run_in) |=> mod_state == led_status_pkg::MOD_STOP)
    else $error("stop not chosen");

  prio_run_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    supply_good_s ##0 (!ext_error && run_in) |=> mod_state == led_status_pkg::MOD_RUN)
    else $error("run not chosen");

  mod_dark_supply_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (supply_absent_in && !critical) ##1 (mod_state == led_status_pkg::MOD_DARK)
    |=> !mod_red_out && !mod_green_out) else $error("indicator lit without supply");

  mod_red_here_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    critical_here_in ##1 critical_here_in |=> mod_red_out == $past(phase_fast) && !mod_green_out)
    else $error("2 Hz red missing");

  mod_red_other_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical_here_in && critical_other_in)[*2] |=> mod_red_out && !mod_green_out)
    else $error("steady red missing");

  mod_green_run_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (run_in && !critical && !supply_absent_in && !supply_window_fail_in && !ext_error)[*2]
    |=> mod_green_out && !mod_red_out) else $error("steady green missing");

  mod_window_blink_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical && !supply_absent_in && supply_window_fail_in)[*2]
    |=> mod_green_out == $past(phase_slow) && !mod_red_out) else $error("window blink wrong");

  mod_stop_blink_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical && !supply_absent_in && !supply_window_fail_in && !ext_error && !run_in)[*2]
    |=> mod_green_out == $past(phase_slow) && !mod_red_out) else $error("stop blink wrong");

  mod_ext_error_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!critical && !supply_absent_in && !supply_window_fail_in && ext_error)[*2]
    |=> mod_red_out != mod_green_out) else $error("red/green alternation wrong");

  // Every input channel is checked, not only the first one
  genvar gi;
  generate
    for (gi = 0; gi < IN_CH; gi++) begin : g_in_chk
      in_mat_dark_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        safety_mat_actuated_in[gi] |=> !input_led_out[gi])
        else $error("mat channel lit");

      in_dark_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (!safety_mat_actuated_in[gi] && !safe_input_channels_in[gi] && !input_dual_error_in[gi])
        |=> !input_led_out[gi]) else $error("idle input lit");

      in_phase_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (!safety_mat_actuated_in[gi] && !safe_input_channels_in[gi] && input_dual_error_in[gi])
        |=> input_led_out[gi] == $past(phase_slow)) else $error("input in-phase wrong");
    end
  endgenerate

  genvar go;
  generate
    for (go = 0; go < OUT_CH; go++) begin : g_out_chk
      out_green_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (output_request_in[go] && !output_test_error_in[go] && !critical)
        |=> output_led_out[go]) else $error("active output dark");

      out_forced_dark_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (critical && !output_test_error_in[go]) |=> !output_led_out[go])
        else $error("forced-off output lit");
    end
  endgenerate

  input_steady_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (safe_input_channels_in[0] && !input_error_in[0] && !safety_mat_actuated_in[0])
    |=> input_led_out[0]) else $error("input indicator not green");
  input_antiphase_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (safe_input_channels_in[0] && input_error_in[0] && !safety_mat_actuated_in[0])
    |=> input_led_out[0] == !$past(phase_slow)) else $error("input antiphase wrong");
  output_blink_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    output_test_error_in[0] |=> output_led_out[0] == $past(phase_slow))
    else $error("output error blink wrong");
  output_dark_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!output_request_in[0] && !output_test_error_in[0]) |=> !output_led_out[0])
    else $error("output indicator lit while off");
endmodule : safe_io_led_status_indicator
`default_nettype wire

/* File: led_panel_model.sv */
// Front-panel observer that counts module-state red transitions
`timescale 1ns/1ps
`default_nettype none
module led_panel_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Observed indicator
  input wire logic mod_red_in,
  // Red transitions seen so far
  output logic [7:0] red_edges_out
);
  logic last_red;
  // An operator judges a blink rate by its changes, not by its level
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      last_red <= 1'b0;
      red_edges_out <= 8'h00;
    end else begin
      last_red <= mod_red_in;
      if (mod_red_in !== last_red) red_edges_out <= red_edges_out + 8'h01;
    end
  end
endmodule : led_panel_model
`default_nettype wire

/* File: tb_safe_io_led_status_indicator.sv */
// Self-checking bench for the safe I/O status indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_safe_io_led_status_indicator;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sa = 1'b0, wf = 1'b0, run = 1'b0, ch = 1'b0, co = 1'b0;
  logic [7:0] lvl = 8'hF0, ierr = 8'h00, derr = 8'h00, mat = 8'h00;
  logic [3:0] req = 4'h0, terr = 4'h0;
  logic red, green, stop;
  logic [7:0] iled, edges, e0;
  logic [3:0] oled, qout;
  int error_cnt = 0;
  int n_compared = 0;
  int r, g, alt, ph, an, op;
  // Inputs {supply_absent, window_fail, run, crit_other, request} beside
  // expected {red, green, safe outputs, app_stop}
  logic [14:0] rows [5] = '{{8'h2F, 7'h3E}, {8'hAF, 7'h1E}, {8'h3F, 7'h41},
                            {8'hB5, 7'h41}, {8'h26, 7'h2C}};

  safe_io_led_status_indicator #(.HALF_CYCLES(4)) u_dut (
    .mclk_in(mclk_in), .reset_in(reset_in),
    .supply_absent_in(sa), .supply_window_fail_in(wf), .run_in(run),
    .critical_here_in(ch), .critical_other_in(co),
    .safe_input_channels_in(lvl), .input_error_in(ierr),
    .input_dual_error_in(derr), .safety_mat_actuated_in(mat),
    .output_request_in(req), .output_test_error_in(terr),
    .mod_red_out(red), .mod_green_out(green),
    .input_led_out(iled), .output_led_out(oled),
    .safe_output_channels_out(qout), .app_stop_out(stop)
  );

  led_panel_model u_panel (
    .mclk_in(mclk_in), .reset_in(reset_in),
    .mod_red_in(red), .red_edges_out(edges)
  );

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Channel and module-state colours both register the shared phase once,
  // so in-phase pairs match in the same cycle
  task automatic observe();
    repeat (3) @(negedge mclk_in);
    r = 0; g = 0; alt = 0; ph = 0; an = 0; op = 0; e0 = edges;
    repeat (16) begin
      @(negedge mclk_in);
      r += red; g += green; alt += (green !== red);
      ph += (red === iled[0]); an += (red !== iled[7]); op += (red === oled[1]);
    end
  endtask : observe

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(negedge mclk_in);
    check({red, green, stop, 1'b0, qout}, 8'h20);
    check({iled[7:4], oled}, 8'h00);
    reset_in = 1'b0;
    for (int i = 0; i < 5; i++) begin
      {sa, wf, run, co, req} = rows[i][14:7];
      repeat (3) @(negedge mclk_in);
      check({1'b0, red, green, qout, stop}, {1'b0, rows[i][6:0]});
      check({4'h0, oled}, {4'h0, rows[i][4:1]});
      check(iled, 8'hF0);
    end
    {sa, co, req} = 6'h0F;
    mat = 8'h30;
    repeat (2) @(negedge mclk_in);
    check(iled, 8'hC0);
    mat = 8'h00;
    ch = 1'b1;
    observe();
    check(8'(r), 8'h08);
    check(8'(g), 8'h00);
    check(edges - e0, 8'h04);
    check({3'h0, qout, stop}, 8'h01);
    ch = 1'b0;
    // Stop and window failure must give the same slow green blink
    for (int k = 0; k < 2; k++) begin
      {run, wf} = (k == 0) ? 2'b00 : 2'b11;
      observe();
      check(8'(r), 8'h00);
      check({7'h00, stop}, (k == 0) ? 8'h01 : 8'h00);
      check(8'(g), 8'h08);
      check(edges - e0, 8'h00);
    end
    {run, wf, req} = 6'h20;
    ierr = 8'h80;
    derr = 8'h01;
    terr = 4'h2;
    observe();
    check(8'(r), 8'h08);
    check(8'(alt), 8'h10);
    check(edges - e0, 8'h02);
    check(8'(ph), 8'h10);
    check(8'(an), 8'h10);
    check(8'(op), 8'h10);
    check({4'h0, oled & 4'hD}, 8'h00);
    summarize();
  end
endmodule : tb_safe_io_led_status_indicator
`default_nettype wire
